// ==== rtl/odtb_consts.svh ====
`ifndef ODTB_CONSTS_SVH
`define ODTB_CONSTS_SVH

// ----------------------------------------------------------------
// capture storage
// ----------------------------------------------------------------
`define ODTB_FIFO_DEPTH      8
`define ODTB_CNT_FULL        4'h8
`define ODTB_CNT_RESET       4'h0
`define ODTB_WORD_RESET      16'h0000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define ODTB_COF_HOLDOFF     2'h2

// ----------------------------------------------------------------
// reset values of the simple breakpoint
// ----------------------------------------------------------------
`define ODTB_BRK_EN_RESET    1'b0
`define ODTB_FTS_RESET       1'b0
`define ODTB_MATCH_RESET     16'h0000

`endif

// ==== rtl/odtb_pkg.sv ====
package odtb_pkg;

`include "odtb_consts.svh"

   // ----------------------------------------------------------------
   // modes and kinds
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      TRG_A_ONLY,
      TRG_A_OR_B,
      TRG_A_THEN_B,
      TRG_A_AND_B_DATA,
      TRG_A_AND_NOT_B_DATA,
      TRG_EVENT_B,
      TRG_A_THEN_EVENT_B,
      TRG_INSIDE_RANGE,
      TRG_OUTSIDE_RANGE
   } odtb_trig_mode_type;

   typedef enum logic [2:0] {
      COF_NONE,
      COF_COND_TAKEN,
      COF_UNCOND_JUMP,
      COF_NEVER_TAKEN,
      COF_INDIRECT,
      COF_INTR_RETURN
   } odtb_cof_kind_type;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic        valid;     // one bus cycle this clock
      logic [15:0] addr;
      logic        readNotWrite;
      logic [7:0]  readData;
      logic [7:0]  writeData;
      logic        opFetch;   // cycle fetches an opcode
      logic        bgAccess;  // access made for the background controller
   } odtb_cpu_bus_type;

   typedef struct packed {
      logic              valid;
      odtb_cof_kind_type kind;
      logic [15:0]       srcAddr;
      logic [15:0]       dstAddr;
   } odtb_cof_type;

   typedef struct packed {
      logic               dbgEnable;
      odtb_trig_mode_type mode;
      logic               opcodeTrackingSelect;
      logic               beginTrace;
      logic               brkEnable;
      logic               tagSelect;
      logic [1:0]         directionQualifyEnable;  // [0] comparator A, [1] B
      logic [1:0]         directionMatchValue;     // 1 read, 0 write
      logic [1:0][15:0]   cmpValue;
   } odtb_dbg_cfg_type;

   typedef struct packed {
      logic                                simpleBreakEnable;
      logic                                forceTagSelect;
      logic [15:0]                         simpleBreakMatch;
      logic                                armed;
      logic                                storing;
      logic                                aFlag;
      logic                                bFlag;
      logic [3:0]                          fifoValidCount;
      logic [`ODTB_FIFO_DEPTH-1:0][15:0]   fifoMem;
      logic [1:0]                          holdoff;
      logic [1:0]                          trkPend;
      logic [1:0][15:0]                    trkAddr;
      logic [15:0]                         lastFetch;
      logic                                forceReq;
      logic                                tagReq;
      logic [7:0]                          fifoHigh;
      logic [7:0]                          fifoLow;
   } odtb_state_type;

endpackage

// ==== rtl/odtb_debug.sv ====
`timescale 1ns/1ps
// Operation
// - simple breakpoint compares address to 16-bit match
// - forced mode breaks on any access there
// - tagged mode marks opcode fetched at match
// - enable resets 0 and gates simple breakpoint requests
// - force/tag select 1 forced, 0 tagged
// - eight-stage capture fifo, address or data
// - comparators A,B with own direction qualify
// - opcode tracking triggers on execution; range modes ignore it
// - magnitude compares for inside/outside range
// - background controller accesses suppress comparators
// - A compares address; B address or data
// - B data uses write bus if A write-qualified
// - trigger breaks, stores data, begins or ends
// - valid word count reported while storing
// - change-of-flow words read high then low
// - event modes store bytes, low read shifts
// - trigger and next two cycles' cof dropped
// - end-trace trigger cof saved as last
// - unarmed low read pushes last fetch address
// - tag request rides opcode; force waits boundary
// - taken conditional stores source; always/never none
// - indirect, interrupt, return store destination
// - arm write sets armed, clears flags, count
module odtb_debug (
   input  wire logic                      clk,              // 10 MHz bus clock
   input  wire logic                      rstn,             // async reset, active low
   input  wire odtb_pkg::odtb_cpu_bus_type cpuBus,          // current cpu bus cycle
   input  wire logic                      opExec,           // opcode reached end of queue
   input  wire logic [15:0]               opExecAddr,       // address of executing opcode
   input  wire odtb_pkg::odtb_cof_type    cof,              // change-of-flow report
   input  wire logic                      scrWrite,         // background status/control write
   input  wire logic                      scrBreakEnable,   // simple_break_enable value
   input  wire logic                      scrForceTag,      // force_tag_select value
   input  wire logic                      matchWrite,       // simple break match write
   input  wire logic [15:0]               matchWriteData,   // simple break match value
   input  wire odtb_pkg::odtb_dbg_cfg_type dbgCfg,          // debug unit controls
   input  wire logic                      armWrite,         // write to the arm bit
   input  wire logic                      armValue,         // value written to arm
   input  wire logic                      fifoHighRead,     // read of trace_fifo_high_byte
   input  wire logic                      fifoLowRead,      // read of trace_fifo_low_byte
   output logic                           forceBreakReq,    // force-type request pulse
   output logic                           tagBreakReq,      // tag-type request pulse
   output logic [15:0]                    simpleBreakMatch, // read-back of match register
   output logic                           simpleBreakEnable,// read-back of enable
   output logic                           forceTagSelect,   // read-back of force/tag
   output logic [7:0]                     traceFifoHigh,    // fifo high byte port
   output logic [7:0]                     traceFifoLow,     // fifo low byte port
   output logic [3:0]                     fifoValidCount,   // valid words in fifo
   output logic                           armedFlag,        // run armed
   output logic                           aMatchFlag,       // comparator A matched
   output logic                           bMatchFlag        // comparator B matched
);
   import odtb_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   odtb_state_type stateReg;
   odtb_state_type stateNext;

   // ----------------------------------------------------------------
   // per-comparator address match and opcode tracking
   // ----------------------------------------------------------------
   logic [1:0] rawHit;
   logic [1:0] trkFire;
   logic [1:0] cmpHit;
   logic       busOk;

   // background controller cycles never reach the comparators
   assign busOk = cpuBus.valid & ~cpuBus.bgAccess;

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch = ch + 1) begin : gCmp
         logic dirOk;
         assign dirOk       = ~dbgCfg.directionQualifyEnable[ch] |
                              (cpuBus.readNotWrite == dbgCfg.directionMatchValue[ch]);
         assign rawHit[ch]  = busOk & dirOk & (cpuBus.addr == dbgCfg.cmpValue[ch]);
         // fire only when the tracked opcode really executes
         assign trkFire[ch] = stateReg.trkPend[ch] & opExec &
                              (opExecAddr == stateReg.trkAddr[ch]);
         assign cmpHit[ch]  = dbgCfg.opcodeTrackingSelect ? trkFire[ch] : rawHit[ch];
      end
   endgenerate

   // ----------------------------------------------------------------
   // data and range compares
   // ----------------------------------------------------------------
   logic [7:0]  dataSel;
   logic        dataEqB;
   logic        aDirOk;
   logic        inRange;
   logic        outRange;
   logic [15:0] cofWord;
   logic        cofStore;
   logic        eventMode;
   logic        fullMode;

   always_comb begin
      // write bus only for a write-qualified comparator A
      if (dbgCfg.directionQualifyEnable[0] && !dbgCfg.directionMatchValue[0]) begin
         dataSel = cpuBus.writeData;
      end else begin
         dataSel = cpuBus.readData;
      end
      dataEqB  = (dataSel == dbgCfg.cmpValue[1][7:0]);
      aDirOk   = ~dbgCfg.directionQualifyEnable[0] |
                 (cpuBus.readNotWrite == dbgCfg.directionMatchValue[0]);
      inRange  = busOk & aDirOk & (cpuBus.addr >= dbgCfg.cmpValue[0]) &
                 (cpuBus.addr <= dbgCfg.cmpValue[1]);
      outRange = busOk & aDirOk & ((cpuBus.addr < dbgCfg.cmpValue[0]) |
                 (cpuBus.addr > dbgCfg.cmpValue[1]));
      eventMode = (dbgCfg.mode == TRG_EVENT_B) || (dbgCfg.mode == TRG_A_THEN_EVENT_B);
      fullMode  = (dbgCfg.mode == TRG_A_AND_B_DATA) || (dbgCfg.mode == TRG_A_AND_NOT_B_DATA);
   end

   // ----------------------------------------------------------------
   // change-of-flow word selection
   // ----------------------------------------------------------------
   always_comb begin
      cofStore = 1'b0;
      cofWord  = `ODTB_WORD_RESET;
      if (cof.valid) begin
         case (cof.kind)
            COF_COND_TAKEN: begin
               cofStore = 1'b1;
               cofWord  = cof.srcAddr;
            end
            COF_INDIRECT, COF_INTR_RETURN: begin
               cofStore = 1'b1;
               cofWord  = cof.dstAddr;
            end
            COF_UNCOND_JUMP, COF_NEVER_TAKEN: begin
               cofStore = 1'b0;
            end
            default: begin
               cofStore = 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // trigger decode
   // ----------------------------------------------------------------
   logic trig;
   logic brkTrig;

   always_comb begin
      case (dbgCfg.mode)
         TRG_A_ONLY:           trig = cmpHit[0];
         TRG_A_OR_B:           trig = cmpHit[0] | cmpHit[1];
         TRG_A_THEN_B:         trig = stateReg.aFlag & cmpHit[1];
         TRG_A_AND_B_DATA:     trig = cmpHit[0] & dataEqB;
         TRG_A_AND_NOT_B_DATA: trig = cmpHit[0] & ~dataEqB;
         TRG_EVENT_B:          trig = cmpHit[1];
         TRG_A_THEN_EVENT_B:   trig = stateReg.aFlag & cmpHit[1];
         TRG_INSIDE_RANGE:     trig = inRange;
         TRG_OUTSIDE_RANGE:    trig = outRange;
         default:              trig = 1'b0;
      endcase
      // a tag request in full modes ignores the data half
      brkTrig = (fullMode && dbgCfg.tagSelect) ? cmpHit[0] : trig;
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic        push;
      logic [15:0] pushWord;
      logic        shift;
      logic        runEnd;
      logic        simpleHit;
      stateNext = stateReg;
      push      = 1'b0;
      pushWord  = `ODTB_WORD_RESET;
      runEnd    = 1'b0;
      shift     = 1'b0;
      simpleHit = 1'b0;
      stateNext.forceReq = 1'b0;
      stateNext.tagReq   = 1'b0;

      // simple breakpoint registers
      if (scrWrite) begin
         stateNext.simpleBreakEnable = scrBreakEnable;
         stateNext.forceTagSelect    = scrForceTag;
      end
      if (matchWrite) begin
         stateNext.simpleBreakMatch = matchWriteData;
      end

      if (cpuBus.valid && cpuBus.opFetch) begin
         stateNext.lastFetch = cpuBus.addr;
      end

      // opcode tracking, one per comparator
      for (int i = 0; i < 2; i++) begin
         if (trkFire[i]) begin
            stateNext.trkPend[i] = 1'b0;
         end
         if (dbgCfg.opcodeTrackingSelect && rawHit[i] && cpuBus.opFetch) begin
            stateNext.trkPend[i] = 1'b1;
            stateNext.trkAddr[i] = cpuBus.addr;
         end
      end

      // arm / disarm
      if (armWrite) begin
         stateNext.armed = armValue;
         if (armValue) begin
            stateNext.aFlag          = 1'b0;
            stateNext.bFlag          = 1'b0;
            stateNext.fifoValidCount = `ODTB_CNT_RESET;
            // end-type runs store from arming, begin-type wait for trigger
            stateNext.storing        = ~dbgCfg.beginTrace & ~eventMode;
            stateNext.holdoff        = 2'h0;
         end
      end
      if (!dbgCfg.dbgEnable) begin
         stateNext.armed = 1'b0;
      end

      // run in progress
      if (stateReg.armed && !armWrite) begin
         // a same-cycle arm write wins over the hardware set
         if (cmpHit[0]) begin
            stateNext.aFlag = 1'b1;
         end
         if (cmpHit[1]) begin
            stateNext.bFlag = 1'b1;
         end
         if (eventMode) begin
            if (trig) begin
               push     = 1'b1;
               pushWord = {8'h00, cpuBus.readNotWrite ? cpuBus.readData : cpuBus.writeData};
            end
         end else if (dbgCfg.beginTrace) begin
            if (stateReg.holdoff != 2'h0 && cpuBus.valid) begin
               stateNext.holdoff = stateReg.holdoff - 2'h1;
            end
            if (trig && !stateReg.storing) begin
               // pipeline delay: triggering cof and two cycles after are lost
               stateNext.storing = 1'b1;
               stateNext.holdoff = `ODTB_COF_HOLDOFF;
            end else if (stateReg.storing && stateReg.holdoff == 2'h0 && cofStore) begin
               push     = 1'b1;
               pushWord = cofWord;
            end
         end else begin
            if (stateReg.storing && cofStore) begin
               push     = 1'b1;
               pushWord = cofWord;
            end
            if (trig) begin
               runEnd = 1'b1;
            end
         end
         if (brkTrig && dbgCfg.brkEnable) begin
            stateNext.tagReq   = dbgCfg.tagSelect;
            stateNext.forceReq = ~dbgCfg.tagSelect;
         end
      end

      // simple breakpoint, gated entirely by its enable
      simpleHit = stateReg.simpleBreakEnable && cpuBus.valid &&
                  (cpuBus.addr == stateReg.simpleBreakMatch);
      if (simpleHit) begin
         if (stateReg.forceTagSelect) begin
            stateNext.forceReq = 1'b1;
         end else if (cpuBus.opFetch) begin
            stateNext.tagReq = 1'b1;
         end
      end

      // profiling when not armed
      if (!stateReg.armed && fifoLowRead) begin
         push     = 1'b1;
         pushWord = stateReg.lastFetch;
      end

      // one shift serves both a push and a low-byte read
      shift = push | fifoLowRead;
      if (shift) begin
         for (int i = `ODTB_FIFO_DEPTH - 1; i > 0; i--) begin
            stateNext.fifoMem[i] = stateReg.fifoMem[i-1];
         end
         stateNext.fifoMem[0] = push ? pushWord : `ODTB_WORD_RESET;
      end
      if (push && stateReg.armed) begin
         if (stateReg.fifoValidCount != `ODTB_CNT_FULL) begin
            stateNext.fifoValidCount = stateReg.fifoValidCount + 4'h1;
         end
         if (dbgCfg.beginTrace || eventMode) begin
            if (stateReg.fifoValidCount == `ODTB_CNT_FULL - 4'h1) begin
               runEnd = 1'b1;
            end
         end
      end else if (fifoLowRead && !push && stateReg.fifoValidCount != `ODTB_CNT_RESET) begin
         stateNext.fifoValidCount = stateReg.fifoValidCount - 4'h1;
      end
      if (runEnd) begin
         stateNext.armed   = 1'b0;
         stateNext.storing = 1'b0;
      end

      // read port presents the oldest word
      stateNext.fifoHigh = stateNext.fifoMem[`ODTB_FIFO_DEPTH-1][15:8];
      stateNext.fifoLow  = stateNext.fifoMem[`ODTB_FIFO_DEPTH-1][7:0];
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         stateReg                   <= '0;
         stateReg.simpleBreakEnable <= `ODTB_BRK_EN_RESET;
         stateReg.forceTagSelect    <= `ODTB_FTS_RESET;
         stateReg.simpleBreakMatch  <= `ODTB_MATCH_RESET;
         stateReg.fifoValidCount    <= `ODTB_CNT_RESET;
      end else begin
         stateReg <= stateNext;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign forceBreakReq     = stateReg.forceReq;
   assign tagBreakReq       = stateReg.tagReq;
   assign simpleBreakMatch  = stateReg.simpleBreakMatch;
   assign simpleBreakEnable = stateReg.simpleBreakEnable;
   assign forceTagSelect    = stateReg.forceTagSelect;
   assign traceFifoHigh     = stateReg.fifoHigh;
   assign traceFifoLow      = stateReg.fifoLow;
   assign fifoValidCount    = stateReg.fifoValidCount;
   assign armedFlag         = stateReg.armed;
   assign aMatchFlag        = stateReg.aFlag;
   assign bMatchFlag        = stateReg.bFlag;

endmodule

// ==== tb/odtb_assertions.sv ====
`timescale 1ns/1ps
module odtb_assertions (
   input wire logic                       clk,               // bus clock
   input wire logic                       rstn,              // reset, low
   input wire odtb_pkg::odtb_cpu_bus_type cpuBus,            // bus cycle
   input wire odtb_pkg::odtb_dbg_cfg_type dbgCfg,            // controls
   input wire logic                       matchWrite,        // match strobe
   input wire logic [15:0]                matchWriteData,    // match value
   input wire logic                       armWrite,          // arm strobe
   input wire logic                       armValue,          // arm value
   input wire logic                       fifoLowRead,       // low read
   input wire logic                       forceBreakReq,     // force pulse
   input wire logic                       tagBreakReq,       // tag pulse
   input wire logic [15:0]                simpleBreakMatch,  // match reg
   input wire logic                       simpleBreakEnable, // enable
   input wire logic                       forceTagSelect,    // type
   input wire logic [7:0]                 traceFifoHigh,     // fifo high
   input wire logic [7:0]                 traceFifoLow,      // fifo low
   input wire logic [3:0]                 fifoValidCount,    // count
   input wire logic                       armedFlag,         // armed
   input wire logic                       aMatchFlag         // flag a
);
   import odtb_pkg::*;
   // ----------------------------------------------------------------
   // breakpoint and capture checks
   // ----------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   logic hit;
   logic aHit;
   assign hit = cpuBus.valid && cpuBus.addr == simpleBreakMatch && simpleBreakEnable;
   assign aHit = cpuBus.valid && !cpuBus.bgAccess && cpuBus.addr == dbgCfg.cmpValue[0];
   force_hit_a: assert property (hit && forceTagSelect |=> forceBreakReq)
      else $error("force request missing");
   tag_fetch_a: assert property (hit && !forceTagSelect && cpuBus.opFetch |=> tagBreakReq)
      else $error("tag request missing");
   brk_gate_a: assert property (!simpleBreakEnable && !dbgCfg.brkEnable |=> !(forceBreakReq || tagBreakReq))
      else $error("request while disabled");
   match_load_a: assert property (matchWrite |=> simpleBreakMatch == $past(matchWriteData))
      else $error("match register not loaded");
   arm_start_a: assert property (armWrite && armValue && dbgCfg.dbgEnable |=> armedFlag && fifoValidCount == 4'h0 && !aMatchFlag)
      else $error("arm did not start run");
   count_step_a: assert property (!armWrite |=> fifoValidCount <= 4'h8 && ($stable(fifoValidCount)
      || fifoValidCount == $past(fifoValidCount) + 4'h1 || fifoValidCount + 4'h1 == $past(fifoValidCount)))
      else $error("count jumped");
   bg_quiet_a: assert property (armedFlag && !aMatchFlag && !armWrite && !dbgCfg.opcodeTrackingSelect
      && cpuBus.valid && cpuBus.bgAccess |=> !aMatchFlag)
      else $error("background access matched");
   a_trigger_a: assert property (armedFlag && !armWrite && dbgCfg.dbgEnable && dbgCfg.mode == TRG_A_ONLY && aHit
      && !dbgCfg.opcodeTrackingSelect && !dbgCfg.directionQualifyEnable[0] |=> aMatchFlag)
      else $error("comparator a flag missing");
   fifo_hold_a: assert property (!armedFlag && !$past(armedFlag) && !fifoLowRead && !armWrite
      |=> $stable({traceFifoHigh, traceFifoLow}))
      else $error("fifo port moved without read");
   cover property (forceBreakReq);
   cover property (tagBreakReq);
   cover property (fifoValidCount == 4'h8);
endmodule

bind odtb_debug odtb_assertions u_chk (.*);

// ==== tb/odtb_cpu_model.sv ====
`timescale 1ns/1ps
module odtb_cpu_model (
   input  wire logic               clk,        // bus clock
   output odtb_pkg::odtb_cpu_bus_type cpuBus,  // bus cycle
   output logic                    opExec,     // opcode executes
   output logic [15:0]             opExecAddr, // its address
   output odtb_pkg::odtb_cof_type  cof         // change of flow
);
   import odtb_pkg::*;
   // ----------------------------------------------------------------
   // one bus cycle, then idle with lines inverted
   // ----------------------------------------------------------------
   // tracking is not exercised, so nothing is reported as executed
   initial begin
      cpuBus = '0;
      cof = '0;
      opExec = 1'b0;
      opExecAddr = 16'h0000;
   end
   task automatic cycle(input logic [15:0] a, input logic f, input logic bg, input logic rnw = 1'b1,
                        input odtb_cof_kind_type k = COF_NONE, input logic [15:0] s = 16'h0000,
                        input logic [15:0] d = 16'h0000);
      logic [7:0] r;
      r = $urandom;
      @(negedge clk);
      cpuBus <= '{1'b1, a, rnw, r, ~r, f, bg};
      cof <= '{k != COF_NONE, k, s, d};
      @(negedge clk);
      cpuBus <= '{1'b0, ~a, ~rnw, ~r, r, 1'b0, 1'b0};
      cof <= '{1'b0, COF_NONE, ~s, ~d};
   endtask
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/1ps
module tb;
   import odtb_pkg::*;
   logic              clk, rstn, scrWrite, scrBreakEnable, scrForceTag, matchWrite, armWrite;
   logic              armValue, fifoHighRead, fifoLowRead, forceBreakReq, tagBreakReq;
   logic              simpleBreakEnable, forceTagSelect, armedFlag, aMatchFlag, bMatchFlag, opExec;
   logic [15:0]       matchWriteData, simpleBreakMatch, opExecAddr, m, s, d;
   logic [7:0]        traceFifoHigh, traceFifoLow;
   logic [3:0]        fifoValidCount;
   odtb_cpu_bus_type  cpuBus;
   odtb_cof_type      cof;
   odtb_dbg_cfg_type  dbgCfg;
   odtb_cof_kind_type k;
   logic [1:0]        notes[$];
   logic [15:0]       words[$];
   logic [15:0]       p[9];
   int                checked, miscompares, n, i;

   odtb_debug DUT (.*);
   odtb_cpu_model cpu (.*);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic close_out;
      $display("checks %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // kind 0 status/control, 1 match, 2 arm
   task automatic wr(input int kind, input logic [15:0] v);
      @(negedge clk);
      scrWrite <= kind == 0;
      matchWrite <= kind == 1;
      armWrite <= kind == 2;
      {scrBreakEnable, scrForceTag} <= v[1:0];
      matchWriteData <= v;
      armValue <= v[0];
      @(negedge clk);
      {scrWrite, matchWrite, armWrite} <= 3'h0;
   endtask
   // high byte first keeps the word coherent
   task automatic rd_low;
      @(negedge clk);
      fifoHighRead <= 1'b1;
      @(negedge clk);
      {fifoHighRead, fifoLowRead} <= 2'h1;
      @(negedge clk);
      fifoLowRead <= 1'b0;
      repeat (2) @(negedge clk);
   endtask

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      repeat (5000) @(posedge clk);
      miscompares++;
      close_out();
   end
   // every break pulse must match the oldest note
   always @(negedge clk) begin
      if (rstn && (forceBreakReq | tagBreakReq) !== 1'b0) begin
         if (notes.size() == 0) check("break pulse", {forceBreakReq, tagBreakReq}, 16'h0000);
         else check("break pulse", {forceBreakReq, tagBreakReq}, notes.pop_front());
      end
   end

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      {scrWrite, scrBreakEnable, scrForceTag, matchWrite, armWrite, armValue} = 6'h00;
      {fifoHighRead, fifoLowRead} = 2'h0;
      matchWriteData = 16'h0000;
      dbgCfg = '0;
      rstn = 1'b0;
      n = $urandom(32'h65c3);
      repeat (5) @(posedge clk);
      @(negedge clk);
      rstn = 1'b1;
      check("enable", simpleBreakEnable, 16'h0000);
      check("count", fifoValidCount, 16'h0000);
      check("armed", armedFlag, 16'h0000);
      $display("test reset done");
      m = $urandom;
      wr(1, m);
      check("match", simpleBreakMatch, m);
      cpu.cycle(m, 1'b1, 1'b0);
      wr(0, 16'h0003);
      check("force select", {simpleBreakEnable, forceTagSelect}, 16'h0003);
      for (i = 0; i < 2; i++) begin
         notes.push_back(2'h2);
         cpu.cycle(m, 1'b0, i[0], i[0]);
      end
      cpu.cycle(m ^ 16'h0100, 1'b0, 1'b0);
      wr(0, 16'h0002);
      notes.push_back(2'h1);
      cpu.cycle(m, 1'b1, 1'b0);
      cpu.cycle(m, 1'b0, 1'b0);
      wr(0, 16'h0000);
      $display("test simple breakpoint done");
      dbgCfg.dbgEnable = 1'b1;
      dbgCfg.mode = TRG_A_ONLY;
      dbgCfg.beginTrace = 1'b1;
      dbgCfg.brkEnable = 1'b1;
      dbgCfg.cmpValue[0] = 16'h8000;
      wr(2, 16'h0001);
      check("armed", armedFlag, 16'h0001);
      cpu.cycle(16'h8000, 1'b0, 1'b1);
      check("flag a", aMatchFlag, 16'h0000);
      notes.push_back(2'h2);
      cpu.cycle(16'h8000, 1'b1, 1'b0, 1'b1, COF_COND_TAKEN, 16'h0100, 16'h0200);
      check("flag a", aMatchFlag, 16'h0001);
      for (i = 0; i < 2; i++) cpu.cycle(16'h1000, 1'b1, 1'b0, 1'b1, COF_INDIRECT, 16'h0300, 16'h0400);
      @(negedge clk);
      check("count", fifoValidCount, 16'h0000);
      for (i = 0; words.size() < 8; i++) begin
         k = odtb_cof_kind_type'(3'(1 + i % 5));
         s = $urandom;
         d = $urandom;
         cpu.cycle(16'h2000 + 16'(i), 1'b1, 1'b0, 1'b1, k, s, d);
         if (k == COF_COND_TAKEN) words.push_back(s);
         if (k == COF_INDIRECT || k == COF_INTR_RETURN) words.push_back(d);
         @(negedge clk);
         check("count", fifoValidCount, 16'(words.size()));
      end
      repeat (3) @(negedge clk);
      check("armed", armedFlag, 16'h0000);
      for (i = 0; i < 8; i++) begin
         check("word", {traceFifoHigh, traceFifoLow}, words[i]);
         rd_low();
      end
      dbgCfg = '0;
      $display("test capture run done");
      for (i = 0; i < 9; i++) begin
         p[i] = $urandom;
         cpu.cycle(p[i], 1'b1, 1'b0);
         rd_low();
         if (i >= 7) check("profile", {traceFifoHigh, traceFifoLow}, p[i - 7]);
      end
      $display("test profiling done");
      check("notes left", 16'(notes.size()), 16'h0000);
      close_out();
   end
endmodule
